// ### awot_pkg.sv
// package: encodings and field positions for the word add unit
package awot_pkg;
  localparam int unsigned AWOT_XLEN = 32;
  localparam int unsigned AWOT_IDXW = 5;
  localparam int unsigned AWOT_NREGS = 32;
  // field positions of the instruction word
  localparam int unsigned AWOT_OP_HI = 31;
  localparam int unsigned AWOT_OP_LO = 26;
  localparam int unsigned AWOT_S1_LO = 21;
  localparam int unsigned AWOT_S2_LO = 16;
  localparam int unsigned AWOT_DST_LO = 11;
  localparam int unsigned AWOT_ZR_HI = 10;
  localparam int unsigned AWOT_ZR_LO = 6;
  localparam int unsigned AWOT_FN_HI = 5;
  localparam int unsigned AWOT_FN_LO = 0;
  // encodings
  localparam logic [5:0] AWOT_OP_REGTYPE = 6'h00;
  localparam logic [5:0] AWOT_FN_ADD_TRAP = 6'h20;
  localparam logic [5:0] AWOT_FN_ADD_NOTRAP = 6'h21;
  localparam logic [31:0] AWOT_REG_RESET = 32'h0000_0000;
  typedef logic [AWOT_XLEN-1:0] awot_word_t;
  typedef logic [AWOT_IDXW-1:0] awot_idx_t;
endpackage : awot_pkg

// ### awot_alu_if.sv
// interface: adder request and answer between the unit and its adder
`timescale 1ns/1ps
interface awot_alu_if;
  import awot_pkg::*;
  awot_word_t op_a;
  awot_word_t op_b;
  awot_word_t sum;
  logic ovf;
  modport core (output op_a, output op_b, input sum, input ovf);
  modport alu (input op_a, input op_b, output sum, output ovf);
endinterface : awot_alu_if

// ### awot_adder.sv
// module: 33-bit sign-extended adder with overflow flag
`timescale 1ns/1ps
module awot_adder (
  awot_alu_if.alu bus
);
  import awot_pkg::*;
  logic [AWOT_XLEN:0] wide;
  // sign-extend both operands so bit 32 keeps the true sign
  assign wide = {bus.op_a[AWOT_XLEN-1], bus.op_a} + {bus.op_b[AWOT_XLEN-1], bus.op_b};
  assign bus.sum = wide[AWOT_XLEN-1:0];
  assign bus.ovf = wide[AWOT_XLEN] ^ wide[AWOT_XLEN-1];
endmodule : awot_adder

// ### awot_core.sv
// module: decode and execute unit for the trapping and plain word add
// ---------------------------------------------------------------
// Overview of operation
// - match major opcode zero and add function
// - source, source and destination indices, five bits
// - add two 32-bit signed register values
// - overflow: keep destination, raise overflow exception
// - no overflow: write sum to destination
// - nontrapping add always writes, never traps
// ---------------------------------------------------------------
`timescale 1ns/1ps
module awot_core (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire awot_pkg::awot_word_t instr,
  input wire awot_pkg::awot_idx_t rd_index,
  input wire logic load_valid,
  input wire awot_pkg::awot_idx_t load_index,
  input wire awot_pkg::awot_word_t load_data,
  output awot_pkg::awot_word_t rd_data_ff,
  output logic done_ff,
  output logic wrote_ff,
  output logic ovf_exc_ff,
  output logic illegal_ff,
  output awot_pkg::awot_word_t result_ff
);
  import awot_pkg::*;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic awot_idx_t fld(input awot_word_t w, input int unsigned lo);
    fld = w[lo +: AWOT_IDXW];
  endfunction : fld

  // one compare serves both add flavours, so they cannot drift apart
  function automatic logic enc_match(input logic [5:0] op, input logic [5:0] fn,
      input logic [5:0] code);
    enc_match = (op == AWOT_OP_REGTYPE) && (fn == code);
  endfunction : enc_match

  // the index decode assumes one register per index value, the overflow tap a 32-bit word
  if (AWOT_NREGS != (1 << AWOT_IDXW)) begin : g_depth_chk
    $error("register count must equal two to the index width");
  end
  if (AWOT_XLEN != 32) begin : g_width_chk
    $error("word width must be 32 bits");
  end

  // word layout, high to low: major opcode, first source, second source,
  // destination, five spare zero bits, function code

  logic [5:0] opc;
  logic [5:0] fnc;
  logic is_trap;
  logic is_notrap;
  awot_idx_t s1_idx;
  awot_idx_t s2_idx;
  awot_idx_t dst_idx;
  assign opc = instr[AWOT_OP_HI:AWOT_OP_LO];
  assign fnc = instr[AWOT_FN_HI:AWOT_FN_LO];
  // bits 10..6 are not checked: nonzero there is the supplier's fault
  assign is_trap = enc_match(opc, fnc, AWOT_FN_ADD_TRAP);
  assign is_notrap = enc_match(opc, fnc, AWOT_FN_ADD_NOTRAP);
  assign s1_idx = fld(instr, AWOT_S1_LO);
  assign s2_idx = fld(instr, AWOT_S2_LO);
  assign dst_idx = fld(instr, AWOT_DST_LO);

  // ---------------------------------------------------------------
  // register file and adder
  // ---------------------------------------------------------------
  awot_word_t regs_ff [AWOT_NREGS];
  awot_alu_if alu_bus ();
  awot_adder u_adder (.bus(alu_bus));
  assign alu_bus.op_a = regs_ff[s1_idx];
  assign alu_bus.op_b = regs_ff[s2_idx];

  // ---------------------------------------------------------------
  // write arbitration
  // ---------------------------------------------------------------
  // the load port stands in for the pipeline's write-back path; an instruction
  // in the same cycle wins and the load is dropped, so one write lands per edge
  logic do_write;
  logic do_load;
  assign do_write = instr_valid && (is_notrap || (is_trap && !alu_bus.ovf));
  assign do_load = load_valid && !instr_valid;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < AWOT_NREGS; i++) begin
        regs_ff[i] <= AWOT_REG_RESET;
      end
    end else if (do_write) begin
      regs_ff[dst_idx] <= alu_bus.sum;
    end else if (do_load) begin
      regs_ff[load_index] <= load_data;
    end
  end

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= instr_valid;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wrote_ff <= 1'b0;
    end else begin
      wrote_ff <= do_write;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ovf_exc_ff <= 1'b0;
    end else begin
      ovf_exc_ff <= instr_valid && is_trap && alu_bus.ovf;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      illegal_ff <= 1'b0;
    end else begin
      illegal_ff <= instr_valid && !is_trap && !is_notrap;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      result_ff <= AWOT_REG_RESET;
    end else begin
      result_ff <= alu_bus.sum;
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  // one cycle late: shows what the previous edge wrote
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_data_ff <= AWOT_REG_RESET;
    end else begin
      rd_data_ff <= regs_ff[rd_index];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  trap_decode_a: assert property (instr_valid && opc == AWOT_OP_REGTYPE && fnc == 6'h20 && alu_bus.ovf |=> ovf_exc_ff)
    else $error("overflowing trap add did not raise exception");
  ovf_keeps_dst_a: assert property (instr_valid && is_trap && alu_bus.ovf |=> regs_ff[$past(dst_idx)] == $past(regs_ff[dst_idx]))
    else $error("destination changed on overflow");
  no_ovf_write_a: assert property (instr_valid && is_trap && !alu_bus.ovf |=> wrote_ff && regs_ff[$past(dst_idx)] == $past(alu_bus.sum))
    else $error("sum not written without overflow");
  notrap_write_a: assert property (instr_valid && is_notrap |=> wrote_ff && !ovf_exc_ff)
    else $error("nontrapping add trapped or did not write");
  ovf_rule_a: assert property (alu_bus.ovf == ((alu_bus.op_a[31] == alu_bus.op_b[31]) && (alu_bus.sum[31] != alu_bus.op_a[31])))
    else $error("overflow flag wrong");
  sum_value_a: assert property (alu_bus.sum == awot_word_t'(alu_bus.op_a + alu_bus.op_b))
    else $error("sum wrong");
  src_index_a: assert property (alu_bus.op_a == regs_ff[instr[25:21]] && alu_bus.op_b == regs_ff[instr[20:16]])
    else $error("source index fields wrong");
  exc_excl_a: assert property (ovf_exc_ff |-> !wrote_ff && done_ff)
    else $error("exception and write together");

  // register-file checks look one edge back through $past
  notrap_sum_a: assert property (instr_valid && is_notrap |=>
      regs_ff[$past(dst_idx)] == $past(alu_bus.sum))
    else $error("nontrapping sum not written");
  illegal_flag_a: assert property (instr_valid && !is_trap && !is_notrap |=>
      illegal_ff && !wrote_ff && !ovf_exc_ff)
    else $error("other encoding not refused");
  idle_quiet_a: assert property (!instr_valid |=>
      !done_ff && !wrote_ff && !ovf_exc_ff && !illegal_ff)
    else $error("status pulse without instruction");
  done_pulse_a: assert property (instr_valid |=>
      done_ff)
    else $error("done missing");
  result_val_a: assert property (instr_valid |=>
      result_ff == $past(alu_bus.op_a + alu_bus.op_b))
    else $error("result value wrong");
  rd_port_a: assert property (1'b1 |=>
      rd_data_ff == $past(regs_ff[rd_index]))
    else $error("read port wrong");
  load_write_a: assert property (load_valid && !instr_valid |=>
      regs_ff[$past(load_index)] == $past(load_data))
    else $error("load not written");
  exc_only_trap_a: assert property (ovf_exc_ff |->
      $past(instr_valid && is_trap))
    else $error("exception without trapping add");
  wrote_legal_a: assert property (wrote_ff |->
      done_ff && !illegal_ff && !ovf_exc_ff)
    else $error("write with bad status");
  load_yield_a: assert property (load_valid && instr_valid && !is_trap && !is_notrap |=>
      regs_ff[$past(load_index)] == $past(regs_ff[load_index]))
    else $error("load landed beside an instruction");

  // ---------------------------------------------------------------
  // scenario covers
  // ---------------------------------------------------------------
  load_c: cover property (load_valid && !instr_valid);
  trap_ovf_c: cover property (instr_valid && is_trap && alu_bus.ovf);
  trap_ok_c: cover property (instr_valid && is_trap && !alu_bus.ovf);
  notrap_ovf_c: cover property (instr_valid && is_notrap && alu_bus.ovf);
  b2b_c: cover property (instr_valid ##1 instr_valid);
endmodule : awot_core

// ### awot_feeder.sv
// partner model: fetch and decode stage handing words to the unit
`timescale 1ns/1ps
module awot_feeder
  import awot_pkg::*;
(
  input wire logic issue,
  input wire logic [5:0] op,
  input wire logic [5:0] fn,
  input wire awot_idx_t dst,
  output logic instr_valid,
  output awot_word_t instr
);
  assign instr_valid = issue;
  // sources equal dst, so each add reads what the last write to dst left there
  assign instr = {op, dst, dst, dst, 5'h00, fn};
endmodule : awot_feeder

// ### tb_add_word_overflow_trap.sv
// testbench: decode table, reset and back-to-back checks
`timescale 1ns/1ps
module tb_add_word_overflow_trap;
  import awot_pkg::*;
  typedef struct {logic [5:0] op; logic [5:0] fn; logic [31:0] ld; logic [31:0] sum;
    logic [3:0] exp;} awot_row_t;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic issue = 1'b0;
  logic [5:0] op = 6'h00;
  logic [5:0] fn = 6'h00;
  awot_idx_t dst = 5'h00;
  awot_idx_t rd_index = 5'h00;
  logic load_valid = 1'b0;
  awot_idx_t load_index = 5'h00;
  awot_word_t load_data = 32'h0000_0000;
  logic instr_valid, done_ff, wrote_ff, ovf_exc_ff, illegal_ff;
  awot_word_t instr, rd_data_ff, result_ff;
  int failures = 0;
  int n_checks = 0;
  // {done, wrote, overflow, illegal}
  // sources equal destination, so each row doubles its loaded value
  awot_row_t rows[11] = '{
    '{6'h00, 6'h20, 32'h2000_0000, 32'h4000_0000, 4'hc},
    '{6'h00, 6'h20, 32'h4000_0000, 32'h8000_0000, 4'ha},
    '{6'h00, 6'h21, 32'h4000_0000, 32'h8000_0000, 4'hc},
    '{6'h00, 6'h20, 32'hc000_0000, 32'h8000_0000, 4'hc},
    '{6'h00, 6'h20, 32'h8000_0000, 32'h0000_0000, 4'ha},
    '{6'h00, 6'h21, 32'h8000_0000, 32'h0000_0000, 4'hc},
    '{6'h00, 6'h20, 32'hffff_ffff, 32'hffff_fffe, 4'hc},
    '{6'h00, 6'h22, 32'h0000_0001, 32'h0000_0002, 4'h9},
    '{6'h01, 6'h20, 32'h0000_0003, 32'h0000_0006, 4'h9},
    '{6'h3f, 6'h20, 32'h7fff_ffff, 32'hffff_fffe, 4'h9},
    '{6'h00, 6'h00, 32'hffff_ffff, 32'hffff_fffe, 4'h9}};
  awot_feeder awot_feeder_i (.issue(issue), .op(op), .fn(fn), .dst(dst),
    .instr_valid(instr_valid), .instr(instr));
  awot_core awot_core_i (.mclk(mclk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
    .load_valid(load_valid), .load_index(load_index), .load_data(load_data),
    .rd_index(rd_index), .rd_data_ff(rd_data_ff), .done_ff(done_ff), .wrote_ff(wrote_ff),
    .ovf_exc_ff(ovf_exc_ff), .illegal_ff(illegal_ff), .result_ff(result_ff));
  initial begin
    forever #25 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  task automatic fire(input logic [5:0] o, input logic [5:0] f, input logic keep);
    @(posedge mclk);
    op <= o;
    fn <= f;
    issue <= 1'b1;
    @(posedge mclk);
    issue <= keep;
    #1;
  endtask : fire
  task automatic load(input awot_idx_t idx, input awot_word_t d);
    @(posedge mclk);
    load_valid <= 1'b1;
    load_index <= idx;
    load_data <= d;
    @(posedge mclk);
    load_valid <= 1'b0;
  endtask : load
  function automatic logic [31:0] flags;
    return {28'h0, done_ff, wrote_ff, ovf_exc_ff, illegal_ff};
  endfunction : flags
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge mclk);
    check("reset flags", 32'h0, flags());
    rstn <= 1'b1;
    foreach (rows[i]) begin
      dst <= awot_idx_t'(i);
      load(awot_idx_t'(i), rows[i].ld);
      fire(rows[i].op, rows[i].fn, 1'b0);
      check("flags", {28'h0, rows[i].exp}, flags());
      check("sum", rows[i].sum, result_ff);
      rd_index <= awot_idx_t'(i);
      @(posedge mclk);
      #1;
      check("dest", rows[i].exp[2] ? rows[i].sum : rows[i].ld, rd_data_ff);
    end
    dst <= 5'h14;
    load(5'h14, 32'h1000_0000);
    fire(6'h00, 6'h20, 1'b1);
    check("back to back add", 32'hc, flags());
    check("back to back sum", 32'h2000_0000, result_ff);
    @(posedge mclk);
    op <= 6'h02;
    #1;
    check("chained add", 32'hc, flags());
    check("chained sum", 32'h4000_0000, result_ff);
    @(posedge mclk);
    issue <= 1'b0;
    #1;
    check("back to back other", 32'h9, flags());
    fire(6'h00, 6'h21, 1'b0);
    rstn = 1'b0;
    #1;
    check("mid reset", 32'h0, flags());
    check("mid reset sum", 32'h0, result_ff);
    @(posedge mclk);
    rstn <= 1'b1;
    rd_index <= 5'h14;
    @(posedge mclk);
    #1;
    check("regs after reset", 32'h0, rd_data_ff);
    check("flags after reset", 32'h0, flags());
    wrap_up();
  end
endmodule : tb_add_word_overflow_trap
